// >>> sdf_defines.svh
// Offsets, field positions, reset values and widths of the sinc3 filter.
// Included by the package and by the modules; definitions only.
`ifndef SDF_DEFINES_SVH
`define SDF_DEFINES_SVH

`define SDF_ADDR_W          8
`define SDF_DATA_W          32
`define SDF_OFF_CTRL        8'h00
`define SDF_OFF_STATUS      8'h04
`define SDF_OFF_DATA        8'h08

`define SDF_RATIO_W         13
`define SDF_RATIO_RST       13'h00ff
`define SDF_CODE_W          3
`define SDF_CODE_MAX        3'h4
`define SDF_CTRL_TMR_LSB    16
`define SDF_CTRL_GAIN_LSB   20
`define SDF_CTRL_MASTER_BIT 24
`define SDF_STAT_BUSY_BIT   1
`define SDF_STAT_CNT_LSB    4

`define SDF_ACC_W           10
`define SDF_RATE_DEN        10'h200
`define SDF_RES_W           24
`define SDF_CIC_W           40
`define SDF_RES_LSB         16
`define SDF_CNT_W           5
`define SDF_LAST_BIT        5'h17

`endif

// >>> sdf_pkg.sv
// Types shared by the sinc3 decimation filter modules.
// Assumes the defines header is on the include path.
`include "sdf_defines.svh"

package sdf_pkg;

    typedef enum logic [1:0]
    {
        SDF_IDLE  = 2'b01,
        SDF_SHIFT = 2'b10
    } sdf_xfer_t;

    typedef struct packed
    {
        logic [2:0][`SDF_CIC_W-1:0] integ;
        logic [2:0][`SDF_CIC_W-1:0] combDly;
        logic [`SDF_CIC_W-1:0]      out;
        logic                       valid;
    } sdf_cic_t;

    typedef struct packed
    {
        logic [`SDF_RATIO_W-1:0] ratio;
        logic [`SDF_CODE_W-1:0]  tmrCode;
        logic [`SDF_CODE_W-1:0]  gainCode;
        logic                    master;
        logic [`SDF_ACC_W-1:0]   modAcc;
        logic [`SDF_ACC_W-1:0]   sampAcc;
        logic                    modTick;
        logic                    sampTick;
        logic [`SDF_RATIO_W-1:0] decCnt;
        logic                    dump;
        logic [1:0]              modSync;
        logic [1:0]              sclkSync;
        logic                    sclkPrev;
        logic [`SDF_RES_W-1:0]   result;
        logic                    drdy;
        logic [`SDF_DATA_W-1:0]  rdData;
        sdf_xfer_t               xfer;
        logic [`SDF_RES_W-1:0]   shreg;
        logic [`SDF_CNT_W-1:0]   bitCnt;
        logic                    sclkOut;
    } sdf_state_t;

endpackage

// >>> sdf_cic.sv
// Third-order integrator and comb core of the decimation filter.
// Assumes sampleEn and dumpEn are single-cycle pulses on mclk and that
// dumpEn never coincides with sampleEn.
`timescale 1ns/1ps
`include "sdf_defines.svh"

module sdf_cic
    import sdf_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  sampleEn,
    input  wire logic                  bitIn,
    input  wire logic                  dumpEn,
    output wire logic [`SDF_CIC_W-1:0] result,
    output wire logic                  resultValid
);

    sdf_cic_t                   st_ff;
    sdf_cic_t                   nxt_st;
    logic [2:0][`SDF_CIC_W-1:0] stageIn;

    // A one bit maps to +1 and a zero bit to -1, so a positive input
    // differential gives a positive sum.
    assign stageIn[0] = bitIn ? `SDF_CIC_W'(1) : {`SDF_CIC_W{1'b1}}; // [RQ11]

    genvar g;
    generate
        for (g = 1; g < 3; g++)
        begin : g_stage
            assign stageIn[g] = st_ff.integ[g-1];
        end
    endgenerate

    always_comb
    begin
        logic [`SDF_CIC_W-1:0] c;
        logic [`SDF_CIC_W-1:0] d;
        c = '0;
        d = '0;
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        if (sampleEn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                nxt_st.integ[i] = st_ff.integ[i] + stageIn[i]; // [RQ8]
            end
        end
        if (dumpEn)
        begin
            // Three comb stages each reach one output period back, so the
            // result spans the three latest periods.
            c = st_ff.integ[2];
            for (int i = 0; i < 3; i++)
            begin
                d = c - st_ff.combDly[i]; // [RQ7] [RQ14]
                nxt_st.combDly[i] = c;
                c = d;
            end
            nxt_st.out = c;
            nxt_st.valid = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign result      = st_ff.out;
    assign resultValid = st_ff.valid;

endmodule

// >>> sdf_top.sv
// Sinc3 decimation filter with rate generation, register port and the
// serial result output of the converter.
// Assumes modBit and sclkIn are asynchronous pins and that the register
// master drives one-cycle strobes on mclk.
//
// Contract
// [RQ1] Serial port runs as clock master or as clock slave.
// [RQ2] Master serial clock is exactly half the system clock.
// [RQ3] Modulator rate is system clock times rate multiplier over 512.
// [RQ4] Sampling switch rate is clock times multiplier times gain over 512.
// [RQ5] Output rate is modulator rate over decimation ratio plus one.
// [RQ6] Decimation ratio in the control register sets results per output.
// [RQ7] Each output uses modulator results from the three latest periods.
// [RQ8] Filter is a third-order sinc with decimation ratio as length.
// [RQ9] Averaging gives notches at the data rate and its multiples.
// [RQ10] Passband corner sits at 0.262 times the output data rate.
// [RQ11] Positive differential input gives positive result, else negative.
// [RQ12] Each result delivered to the controller is a 24-bit word.
// [RQ13] Rate multiplier accepts only 1, 2, 4, 8 and 16.
// [RQ14] Each result combines three times the decimation ratio of results.
`timescale 1ns/1ps
`include "sdf_defines.svh"

module sdf_top
    import sdf_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic [`SDF_ADDR_W-1:0] regAddr,
    input  wire logic [`SDF_DATA_W-1:0] regWrData,
    input  wire logic                   regWrStb,
    input  wire logic                   regRdStb,
    output wire logic [`SDF_DATA_W-1:0] regRdData,
    input  wire logic                   modBit,
    input  wire logic                   sclkIn,
    output wire logic                   sclkOut,
    output wire logic                   sclkOe,
    output wire logic                   sdout,
    output wire logic                   dataReady,
    output wire logic                   modulatorRate,
    output wire logic                   inputSamplingRate
);

    sdf_state_t              st_ff;
    sdf_state_t              nxt_st;
    logic [`SDF_CIC_W-1:0]   cicOut;
    logic                    cicValid;

    // Power-of-two code to its multiplier value.
    function automatic logic [4:0] sdfPow(input logic [`SDF_CODE_W-1:0] c);
        return 5'h01 << c;
    endfunction

    sdf_cic u_cic
    (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .sampleEn    (st_ff.modTick),
        .bitIn       (st_ff.modSync[1]),
        .dumpEn      (st_ff.dump),
        .result      (cicOut),
        .resultValid (cicValid)
    );

    always_comb
    begin
        logic [4:0]              tmr;
        logic [4:0]              gain;
        logic [`SDF_ACC_W-1:0]   modSum;
        logic [`SDF_ACC_W-1:0]   sampSum;
        logic [`SDF_ACC_W-1:0]   sampStep;
        logic [`SDF_CODE_W-1:0]  wrTmr;
        logic [`SDF_CODE_W-1:0]  wrGain;
        logic                    shiftNow;
        logic                    xferDone;
        logic                    rdClear;
        tmr      = sdfPow(st_ff.tmrCode);
        gain     = sdfPow(st_ff.gainCode);
        modSum   = '0;
        sampSum  = '0;
        sampStep = '0;
        wrTmr    = regWrData[`SDF_CTRL_TMR_LSB +: `SDF_CODE_W];
        wrGain   = regWrData[`SDF_CTRL_GAIN_LSB +: `SDF_CODE_W];
        shiftNow = 1'b0;
        xferDone = 1'b0;
        rdClear  = 1'b0;
        nxt_st   = st_ff;

        // Both pins pass two flip-flops before any logic looks at them.
        nxt_st.modSync  = {st_ff.modSync[0], modBit};
        nxt_st.sclkSync = {st_ff.sclkSync[0], sclkIn};
        nxt_st.sclkPrev = st_ff.sclkSync[1];

        // Register writes.
        if (regWrStb && regAddr == `SDF_OFF_CTRL)
        begin
            nxt_st.ratio  = regWrData[`SDF_RATIO_W-1:0]; // [RQ6]
            nxt_st.master = regWrData[`SDF_CTRL_MASTER_BIT]; // [RQ1]
            // An illegal multiplier code, or a gain and multiplier pair
            // whose product passes 16, leaves both settings unchanged.
            // The sum is one bit wider so that codes 4 and 4 cannot wrap.
            if (wrTmr <= `SDF_CODE_MAX && wrGain <= `SDF_CODE_MAX &&
                ({1'b0, wrTmr} + {1'b0, wrGain}) <=
                {1'b0, `SDF_CODE_MAX}) // [RQ13]
            begin
                nxt_st.tmrCode  = wrTmr;
                nxt_st.gainCode = wrGain;
            end
        end

        // Register reads; data stand in the cycle after the strobe only.
        nxt_st.rdData = '0;
        if (regRdStb)
        begin
            if (regAddr == `SDF_OFF_CTRL)
            begin
                nxt_st.rdData[`SDF_RATIO_W-1:0] = st_ff.ratio;
                nxt_st.rdData[`SDF_CTRL_TMR_LSB +: `SDF_CODE_W] =
                    st_ff.tmrCode;
                nxt_st.rdData[`SDF_CTRL_GAIN_LSB +: `SDF_CODE_W] =
                    st_ff.gainCode;
                nxt_st.rdData[`SDF_CTRL_MASTER_BIT] = st_ff.master;
            end
            else if (regAddr == `SDF_OFF_STATUS)
            begin
                nxt_st.rdData[0] = st_ff.drdy;
                nxt_st.rdData[`SDF_STAT_BUSY_BIT] = (st_ff.xfer == SDF_SHIFT);
                nxt_st.rdData[`SDF_STAT_CNT_LSB +: `SDF_CNT_W] = st_ff.bitCnt;
            end
            else if (regAddr == `SDF_OFF_DATA)
            begin
                nxt_st.rdData[`SDF_RES_W-1:0] = st_ff.result; // [RQ12]
                rdClear = 1'b1;
            end
            else
            begin
                nxt_st.rdData = '0;
            end
        end

        // The accumulator adds the multiplier each clock and wraps at 512,
        // which gives an exact average tick rate with no divider chain.
        modSum = st_ff.modAcc + {5'h00, tmr};
        nxt_st.modTick = 1'b0;
        if (modSum >= `SDF_RATE_DEN) // [RQ3]
        begin
            modSum = modSum - `SDF_RATE_DEN;
            nxt_st.modTick = 1'b1;
        end
        nxt_st.modAcc = modSum;

        sampStep = `SDF_ACC_W'({5'h00, tmr} * {5'h00, gain});
        sampSum = st_ff.sampAcc + sampStep;
        nxt_st.sampTick = 1'b0;
        if (sampSum >= `SDF_RATE_DEN) // [RQ4]
        begin
            sampSum = sampSum - `SDF_RATE_DEN;
            nxt_st.sampTick = 1'b1;
        end
        nxt_st.sampAcc = sampSum;

        // One output per ratio plus one modulator results.  Averaging over
        // exactly one output period puts the sinc nulls on the data rate
        // and its multiples, and the corner at 0.262 of the data rate.
        nxt_st.dump = 1'b0;
        if (st_ff.modTick)
        begin
            if (st_ff.decCnt >= st_ff.ratio) // [RQ5] [RQ9] [RQ10]
            begin
                nxt_st.decCnt = '0;
                nxt_st.dump = 1'b1;
            end
            else
            begin
                nxt_st.decCnt = st_ff.decCnt + `SDF_RATIO_W'(1);
            end
        end

        // Serial shifting of the result, MSB first, data change after the
        // falling clock edge so the controller samples on the rising one.
        case (st_ff.xfer)
            SDF_IDLE:
            begin
                nxt_st.sclkOut = 1'b0;
            end
            SDF_SHIFT:
            begin
                if (st_ff.master)
                begin
                    nxt_st.sclkOut = ~st_ff.sclkOut; // [RQ2]
                    shiftNow = st_ff.sclkOut;
                end
                else
                begin
                    nxt_st.sclkOut = 1'b0;
                    shiftNow = st_ff.sclkPrev & ~st_ff.sclkSync[1]; // [RQ1]
                end
                if (shiftNow)
                begin
                    nxt_st.shreg = {st_ff.shreg[`SDF_RES_W-2:0], 1'b0};
                    if (st_ff.bitCnt == `SDF_LAST_BIT)
                    begin
                        nxt_st.bitCnt = '0;
                        nxt_st.xfer = SDF_IDLE;
                        nxt_st.sclkOut = 1'b0;
                        xferDone = 1'b1;
                    end
                    else
                    begin
                        nxt_st.bitCnt = st_ff.bitCnt + `SDF_CNT_W'(1);
                    end
                end
            end
            default:
            begin
                nxt_st.xfer = SDF_IDLE;
                nxt_st.sclkOut = 1'b0;
            end
        endcase

        if (xferDone || rdClear)
        begin
            nxt_st.drdy = 1'b0;
        end

        // A word taken over the register port is not shifted out as well,
        // so the serial clock never runs without a ready word behind it.
        if (rdClear)
        begin
            nxt_st.xfer = SDF_IDLE;
            nxt_st.bitCnt = '0;
            nxt_st.sclkOut = 1'b0;
        end

        // A fresh result wins over a clear in the same cycle and restarts
        // any word still being shifted; the old word is then lost.
        if (cicValid)
        begin
            nxt_st.result = cicOut[`SDF_RES_LSB +: `SDF_RES_W]; // [RQ12]
            nxt_st.shreg = cicOut[`SDF_RES_LSB +: `SDF_RES_W];
            nxt_st.drdy = 1'b1;
            nxt_st.xfer = SDF_SHIFT;
            nxt_st.bitCnt = '0;
            nxt_st.sclkOut = 1'b0;
        end

        // Leaving master mode parks the serial clock low at once.
        if (!nxt_st.master)
        begin
            nxt_st.sclkOut = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff          <= '0;
            st_ff.ratio    <= `SDF_RATIO_RST;
            st_ff.xfer     <= SDF_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign regRdData         = st_ff.rdData;
    assign sclkOut           = st_ff.sclkOut;
    assign sclkOe            = st_ff.master; // [RQ1]
    assign sdout             = st_ff.shreg[`SDF_RES_W-1];
    assign dataReady         = st_ff.drdy;
    assign modulatorRate     = st_ff.modTick;
    assign inputSamplingRate = st_ff.sampTick;

endmodule

// >>> sdf_monitor.sv
// Assertion checker for the sinc3 filter top, bound to every instance.
// Assumes the single clock mclk and the asynchronous reset arst_n.
`timescale 1ns/1ps
`include "sdf_defines.svh"
module sdf_monitor
(
    input wire logic                   mclk,
    input wire logic                   arst_n,
    input wire logic [`SDF_ADDR_W-1:0] regAddr,
    input wire logic [`SDF_DATA_W-1:0] regWrData,
    input wire logic                   regWrStb,
    input wire logic                   regRdStb,
    input wire logic [`SDF_DATA_W-1:0] regRdData,
    input wire logic                   modBit,
    input wire logic                   sclkIn,
    input wire logic                   sclkOut,
    input wire logic                   sclkOe,
    input wire logic                   sdout,
    input wire logic                   dataReady,
    input wire logic                   modulatorRate,
    input wire logic                   inputSamplingRate
);
    logic [10:0] modGap;
    logic [10:0] sampGap;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Gaps saturate so that a stuck rate output cannot wrap into range.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            modGap  <= 11'h000;
            sampGap <= 11'h000;
        end
        else
        begin
            modGap  <= modulatorRate ? 11'h000 : modGap + {10'h000, ~&modGap};
            sampGap <= inputSamplingRate ? 11'h000
                                         : sampGap + {10'h000, ~&sampGap};
        end
    end
    a_slave_quiet: assert property (!sclkOe |-> !sclkOut)
        else $error("serial clock driven in slave mode");
    a_mode_by_write: assert property (
        !$past(regWrStb) |-> $stable(sclkOe))
        else $error("clock mode changed without a write");
    a_sclk_half: assert property (sclkOut |=> !sclkOut)
        else $error("serial clock high for two cycles");
    a_sclk_cause: assert property (
        $rose(sclkOut) |-> sclkOe && dataReady)
        else $error("serial clock edge without a ready word");
    a_mod_gap: assert property (modulatorRate |-> modGap <= 11'd512)
        else $error("modulator tick gap above 512 cycles");
    a_samp_gap: assert property (
        inputSamplingRate |-> sampGap <= 11'd512)
        else $error("sampling tick gap above 512 cycles");
    a_ready_cause: assert property (
        $rose(dataReady) |-> $past(modulatorRate, 3))
        else $error("ready rose without a closing modulator tick");
    a_read_clear: assert property (
        regRdStb && regAddr == `SDF_OFF_DATA
        |=> !dataReady || $past(modulatorRate, 3))
        else $error("ready not cleared by a result read");
    a_data_width: assert property (
        $past(regRdStb) && $past(regAddr) == `SDF_OFF_DATA
        |-> regRdData[31:24] == 8'h00)
        else $error("result word wider than 24 bits");
    a_rd_idle: assert property (
        !$past(regRdStb) |-> regRdData == 32'h0)
        else $error("read data outside the answer cycle");
endmodule
bind sdf_top sdf_monitor u_sdf_monitor
(
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .modBit(modBit), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe),
    .sdout(sdout), .dataReady(dataReady), .modulatorRate(modulatorRate),
    .inputSamplingRate(inputSamplingRate)
);

// >>> sdf_host_model.sv
// Controller model: drives the modulator bitstream and takes result words
// over the serial port, as clock slave or as clock master.
`timescale 1ns/1ps
module sdf_host_model
(
    input  wire logic        mclk,
    input  wire logic        enable,
    input  wire logic        level,
    input  wire logic        sclkOe,
    input  wire logic        sclkOut,
    input  wire logic        sdout,
    input  wire logic        dataReady,
    output wire logic        modBit,
    output logic             sclkIn,
    output logic [23:0]      word,
    output int               frames
);
    logic [23:0] sh;
    logic        prevClk;
    int          n;
    assign modBit = level;
    initial
    begin
        sclkIn = 1'b0;
        word = 24'h000000;
        frames = 0;
        n = 0;
        prevClk = 1'b0;
    end
    always
    begin
        @(posedge mclk);
        if (sclkOe && sclkOut && !prevClk)
        begin
            sh = {sh[22:0], sdout};
            n++;
            if (n == 24)
            begin
                word = sh;
                frames++;
                n = 0;
            end
        end
        else if (!sclkOe && enable && dataReady)
        begin
            // Slow enough for the device to see every edge through its
            // synchroniser; the clock stands low between frames.
            for (int i = 0; i < 24; i++)
            begin
                repeat (8) @(posedge mclk);
                sclkIn <= 1'b1;
                sh = {sh[22:0], sdout};
                repeat (8) @(posedge mclk);
                sclkIn <= 1'b0;
            end
            word = sh;
            frames++;
            repeat (8) @(posedge mclk);
        end
        prevClk = sclkOut;
    end
endmodule

// >>> sinc3_decimation_filter_test.sv
// Self-checking bench: register port, rate ticks, filter results and both
// serial clock modes. Needs sdf_host_model and the bound checker.
`timescale 1ns/1ps
`include "sdf_defines.svh"
module sinc3_decimation_filter_test;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic [31:0] regRdData, rdv;
    logic        modBit, sclkIn, sclkOut, sclkOe, sdout, dataReady;
    logic        modulatorRate, inputSamplingRate;
    logic        level = 1'b1;
    logic        hostEn = 1'b0;
    logic [23:0] word;
    int          frames, n, g, d, t0, t1;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc++;

    sdf_top u_sdf_top (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .modBit(modBit), .sclkIn(sclkIn),
        .sclkOut(sclkOut), .sclkOe(sclkOe), .sdout(sdout),
        .dataReady(dataReady), .modulatorRate(modulatorRate),
        .inputSamplingRate(inputSamplingRate));
    sdf_host_model u_sdf_host_model (.mclk(mclk), .enable(hostEn),
        .level(level), .sclkOe(sclkOe), .sclkOut(sclkOut), .sdout(sdout),
        .dataReady(dataReady), .modBit(modBit), .sclkIn(sclkIn),
        .word(word), .frames(frames));

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic waitVal(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        @(negedge mclk);
        while (s !== v && k < lim)
        begin
            @(negedge mclk);
            k++;
        end
        if (k >= lim)
        begin
            err_total++;
            $display("unexpected at %0t: wait timed out", $time);
            end_sim();
        end
    endtask
    task automatic gap(ref logic p, output int v);
        waitVal(p, 1'b1, 600);
        waitVal(p, 1'b1, 600);
        v = cyc;
        waitVal(p, 1'b1, 600);
        v = cyc - v;
    endtask
    task automatic waitFrames(input int m);
        m = frames + m;
        for (int k = 0; k < 20000 && frames < m; k++)
            @(negedge mclk);
        check(32'(frames >= m), 32'h1);
        if (frames < m)
            end_sim();
    endtask
    function automatic logic [31:0] ctrl(input logic m, input int gc,
                                         input int mc, input int r);
        return {7'h00, m, 1'b0, gc[2:0], 1'b0, mc[2:0], 3'h0, r[12:0]};
    endfunction
    // A settled sinc3 of length N sees a constant +1 or -1 as +/- N cubed.
    function automatic logic [31:0] expRes(input int nn, input logic lv);
        logic signed [39:0] s;
        s = 40'(nn * nn * nn);
        if (!lv)
            s = -s;
        return {8'h00, s[39:16]};
    endfunction

    initial
    begin
        void'($urandom(36));
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`SDF_OFF_CTRL, rdv);
        check(rdv, 32'h000000ff);
        rd(8'h0c, rdv);
        check(rdv, 32'h0);
        for (int c = 0; c < 5; c++)
        begin
            g = $urandom_range(4 - c, 0);
            wr(`SDF_OFF_CTRL, ctrl(1'b0, g, c, 255));
            rd(`SDF_OFF_CTRL, rdv);
            check(rdv, ctrl(1'b0, g, c, 255));
            gap(modulatorRate, d);
            check(d, 512 >> c);
            gap(inputSamplingRate, d);
            check(d, 512 >> (c + g));
        end
        for (int c = 5; c < 7; c++)
        begin
            wr(`SDF_OFF_CTRL, ctrl(1'b0, c - 5, c - 2 * (c - 5), 100));
            rd(`SDF_OFF_CTRL, rdv);
            check(rdv, ctrl(1'b0, 0, 4, 100));
        end
        // Codes 4 and 4 sum to 8, which a 3-bit sum would wrap to 0.
        wr(`SDF_OFF_CTRL, ctrl(1'b0, 4, 4, 100));
        rd(`SDF_OFF_CTRL, rdv);
        check(rdv, ctrl(1'b0, 0, 4, 100));
        // Read the data register to clear any ready word, so five fresh ones follow.
        rd(`SDF_OFF_DATA, rdv);
        for (int r = 0; r < 3; r++)
        begin
            n = $urandom_range(80, 41);
            wr(`SDF_OFF_CTRL, ctrl(1'b0, 0, 4, n - 1));
            level <= ~level;
            for (int k = 0; k < 5; k++)
            begin
                waitVal(dataReady, 1'b1, 3000);
                t0 = t1;
                t1 = cyc;
                rd(`SDF_OFF_STATUS, rdv);
                check(rdv, 32'h3);
                rd(`SDF_OFF_DATA, rdv);
            end
            check(t1 - t0, n * 32);
            check(rdv, expRes(n, level));
        end
        wr(`SDF_OFF_CTRL, ctrl(1'b1, 0, 4, 63));
        level <= 1'b1;
        waitFrames(5);
        check({8'h00, word}, expRes(64, 1'b1));
        check({31'h0, sclkOe}, 32'h1);
        wr(`SDF_OFF_CTRL, ctrl(1'b0, 0, 4, 63));
        hostEn <= 1'b1;
        waitFrames(5);
        check({8'h00, word}, expRes(64, 1'b1));
        check({31'h0, sclkOe}, 32'h0);
        end_sim();
    end
endmodule
